//--- apmc_defines.vh
`ifndef APMC_DEFINES_VH
`define APMC_DEFINES_VH

// ==========================================================================
// Register offsets.
// ==========================================================================
`define APMC_ADDR_INACT_THRESH 8'h25
`define APMC_ADDR_INACT_TIME 8'h26
`define APMC_ADDR_RATE_LP 8'h2C
`define APMC_ADDR_POWER_CONTROL 8'h2D

// ==========================================================================
// Field positions.
// ==========================================================================
`define APMC_RATE_CODE_MSB 3
`define APMC_RATE_CODE_LSB 0
`define APMC_LOW_POWER_BIT 4
`define APMC_MEASURE_BIT 3
`define APMC_AUTO_SLEEP_BIT 4
`define APMC_LINK_BIT 5

// ==========================================================================
// Reset values.
// ==========================================================================
`define APMC_RST_INACT_THRESH 8'h00
`define APMC_RST_INACT_TIME 8'h00
`define APMC_RST_RATE_LP 8'h0A
`define APMC_RST_POWER_CONTROL 8'h00
`define APMC_RST_RDATA 8'h00

// ==========================================================================
// Rate codes and power modes.
// ==========================================================================
`define APMC_RATE_CODE_MAX 4'hF
`define APMC_SLEEP_RATE_CODE 4'h6
`define APMC_MODE_STANDBY 2'h0
`define APMC_MODE_MEASURE 2'h1
`define APMC_MODE_SLEEP 2'h2

// ==========================================================================
// Timing.
// ==========================================================================
`define APMC_CLK_HZ 10000000
`define APMC_ODR_MAX_HZ 3200
`define APMC_ODR_BASE_CYCLES (`APMC_CLK_HZ / `APMC_ODR_MAX_HZ)
`define APMC_CNT_W 27

`endif

//--- apmc_host.sv
`timescale 1ns/1ps

// ===================================
// Host bus master model.
// ===================================
module apmc_host
(
  input wire clock,
  input wire [7:0] rdata,
  input wire valid,
  output logic cs_n,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial
  begin
    cs_n = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Chip-select level, changed off the sampling edge.
  task sel(input logic v);
    @(negedge clock);
    cs_n = v;
  endtask
  // Released lines show the inverse so stale values never match.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    addr = ~a;
    d = (valid === 1'b1) ? rdata : ~rdata;
  endtask
endmodule

//--- apmc_regfile.v
`timescale 1ns/1ps
`include "apmc_defines.vh"

module apmc_regfile
(
  clock,
  rst,
  wr_en,
  rd_en,
  addr,
  wdata,
  rdata_q,
  rd_valid_q,
  thresh_q,
  time_q,
  rate_lp_q,
  power_control_q
);
  input wire clock;
  input wire rst;
  input wire wr_en;
  input wire rd_en;
  input wire [7:0] addr;
  input wire [7:0] wdata;
  output reg [7:0] rdata_q;
  output reg rd_valid_q;
  output reg [7:0] thresh_q;
  output reg [7:0] time_q;
  output reg [7:0] rate_lp_q;
  output reg [7:0] power_control_q;

  reg [7:0] rdata_d;

  // ========================================================================
  // Read mux; unmapped addresses read as zero.
  // ========================================================================
  always @*
  begin
    case (addr)
      `APMC_ADDR_INACT_THRESH: rdata_d = thresh_q;
      `APMC_ADDR_INACT_TIME: rdata_d = time_q;
      `APMC_ADDR_RATE_LP: rdata_d = rate_lp_q;
      `APMC_ADDR_POWER_CONTROL: rdata_d = power_control_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // ========================================================================
  // Storage. Writes are taken in every power mode.
  // ========================================================================
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      thresh_q <= `APMC_RST_INACT_THRESH;
      time_q <= `APMC_RST_INACT_TIME;
      rate_lp_q <= `APMC_RST_RATE_LP;
      power_control_q <= `APMC_RST_POWER_CONTROL;
      rdata_q <= `APMC_RST_RDATA;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_en & ~wr_en;
      // Write cycles return zero so nothing stale leaks onto the bus.
      if (rd_en & ~wr_en)
      begin
        rdata_q <= rdata_d;
      end
      else
      begin
        rdata_q <= `APMC_RST_RDATA;
      end
      if (wr_en)
      begin
        case (addr)
          `APMC_ADDR_INACT_THRESH: thresh_q <= wdata;
          `APMC_ADDR_INACT_TIME: time_q <= wdata;
          `APMC_ADDR_RATE_LP: rate_lp_q <= wdata;
          `APMC_ADDR_POWER_CONTROL: power_control_q <= wdata;
          default: thresh_q <= thresh_q;
        endcase
      end
    end
  end

endmodule

//--- apmc_top.v
// Overview of operation
// RQ1: After power-up reset the device sits in standby, sensing off.
// RQ2: Setting the measure bit of power control enters measurement mode.
// RQ3: Clearing the measure bit returns the device to standby.
// RQ4: All registers are readable and writable while in standby.
// RQ5: Host should configure in standby and set measure last.
// RQ6: Four-bit rate code; 1111 is 3200 Hz, each lower code halves.
// RQ7: Low-power bit of the rate register selects low power mode.
// RQ8: Low power mode halves the internal sampling rate at equal data rate.
// RQ9: Host should use low power only from 12.5 Hz to 400 Hz.
// RQ10: With auto sleep armed the device sleeps during inactivity.
// RQ11: Host writes inactivity threshold and time, then sets sleep and link.
// RQ12: While asleep the device samples at a rate below 8 Hz; code gives 6.25 Hz output but 12.5 Hz internal samples unless low power.
// RQ13: No measurements are made in standby.
// RQ14: Entering standby leaves stored FIFO samples intact.
// RQ15: The serial port is only ever a target, never a bus master.
// RQ16: A chip-select held high selects I2C mode.
// RQ17: In SPI mode the master drives chip-select to frame transfers.
// RQ18: Chip-select is always tied high or actively driven.
// RQ19: The master ignores data returned during writes.
// RQ20: Three states; sleep only from measuring; measure clear forces standby.
`timescale 1ns/1ps
`include "apmc_defines.vh"

module apmc_top
#(
  parameter ODR_BASE_CYCLES = `APMC_ODR_BASE_CYCLES,
  parameter CNT_W = `APMC_CNT_W
)
(
  clock,
  rst,
  cs_n,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  sample_inactive,
  sample_active,
  reg_rdata_q,
  reg_rd_valid_q,
  i2c_mode_q,
  mode_q,
  sense_enable_q,
  sample_strobe_q,
  odr_strobe_q,
  low_power_q,
  fifo_hold_q,
  inact_threshold_q
);
  input wire clock;
  input wire rst;
  input wire cs_n;
  input wire reg_wr_en;
  input wire reg_rd_en;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire sample_inactive;
  input wire sample_active;
  output wire [7:0] reg_rdata_q;
  output wire reg_rd_valid_q;
  output reg i2c_mode_q;
  output reg [1:0] mode_q;
  output reg sense_enable_q;
  output reg sample_strobe_q;
  output reg odr_strobe_q;
  output reg low_power_q;
  output reg fifo_hold_q;
  output wire [7:0] inact_threshold_q;

  localparam [1:0] ST_STANDBY = `APMC_MODE_STANDBY;
  localparam [1:0] ST_MEASURE = `APMC_MODE_MEASURE;
  localparam [1:0] ST_SLEEP = `APMC_MODE_SLEEP;
  localparam [CNT_W-1:0] BASE_W = ODR_BASE_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE_W = {{(CNT_W-1){1'b0}}, 1'b1};

  wire [7:0] time_w;
  wire [7:0] rate_lp_w;
  wire [7:0] power_control_w;
  wire measure_w;
  wire armed_w;
  wire [3:0] eff_code_w;
  wire [3:0] shift_w;
  wire [CNT_W-1:0] odr_period_w;
  wire [CNT_W-1:0] int_period_w;
  wire tick_w;
  reg [1:0] mode_d;
  reg [CNT_W-1:0] cnt_q;
  reg phase_q;
  reg [7:0] inact_cnt_q;

  // ========================================================================
  // Register file on the target side of the serial port.
  // ========================================================================
  // The port has request inputs only; it never starts a transfer of its
  // own. Write cycles answer with zero data and no valid. (see RQ15)
  apmc_regfile u_regs
  (
    .clock(clock),
    .rst(rst),
    .wr_en(reg_wr_en),
    .rd_en(reg_rd_en),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .rdata_q(reg_rdata_q),
    .rd_valid_q(reg_rd_valid_q),
    .thresh_q(inact_threshold_q),
    .time_q(time_w),
    .rate_lp_q(rate_lp_w),
    .power_control_q(power_control_w)
  ); // see RQ4

  assign measure_w = power_control_w[`APMC_MEASURE_BIT];
  assign armed_w = power_control_w[`APMC_AUTO_SLEEP_BIT] &
    power_control_w[`APMC_LINK_BIT];

  // ========================================================================
  // Interface mode from the chip-select level.
  // ========================================================================
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      i2c_mode_q <= 1'b1;
    end
    else
    begin
      i2c_mode_q <= cs_n; // see RQ16
    end
  end

  // ========================================================================
  // Power-mode state machine.
  // ========================================================================
  always @*
  begin
    mode_d = mode_q;
    case (mode_q)
      ST_STANDBY:
      begin
        if (measure_w)
        begin
          mode_d = ST_MEASURE; // see RQ2
        end
      end
      ST_MEASURE:
      begin
        if (armed_w && (time_w != 8'h00) && (inact_cnt_q >= time_w))
        begin
          mode_d = ST_SLEEP; // see RQ10
        end
      end
      ST_SLEEP:
      begin
        if (!armed_w || (odr_strobe_q && sample_active))
        begin
          mode_d = ST_MEASURE;
        end
      end
      default:
      begin
        mode_d = ST_STANDBY;
      end
    endcase
    if (!measure_w)
    begin
      mode_d = ST_STANDBY; // see RQ3, RQ20
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= ST_STANDBY; // see RQ1
      sense_enable_q <= 1'b0;
      fifo_hold_q <= 1'b1;
      low_power_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      sense_enable_q <= (mode_d != ST_STANDBY); // see RQ13
      // Standby only freezes the FIFO; it never clears it. (see RQ14)
      fifo_hold_q <= (mode_d == ST_STANDBY);
      low_power_q <= rate_lp_w[`APMC_LOW_POWER_BIT]; // see RQ7
    end
  end

  // ========================================================================
  // Sampling timebase.
  // ========================================================================
  // Asleep, a fixed sub-8 Hz code overrides the programmed one.
  assign eff_code_w = (mode_q == ST_SLEEP) ? `APMC_SLEEP_RATE_CODE :
    rate_lp_w[`APMC_RATE_CODE_MSB:`APMC_RATE_CODE_LSB]; // see RQ12
  assign shift_w = `APMC_RATE_CODE_MAX - eff_code_w;
  assign odr_period_w = BASE_W << shift_w; // see RQ6
  // Normal mode samples twice per output sample, low power once.
  assign int_period_w = low_power_q ? odr_period_w :
    {1'b0, odr_period_w[CNT_W-1:1]}; // see RQ8
  // Greater-or-equal keeps the counter sane when the period shrinks.
  assign tick_w = (cnt_q >= (int_period_w - ONE_W));

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= {CNT_W{1'b0}};
      phase_q <= 1'b0;
      sample_strobe_q <= 1'b0;
      odr_strobe_q <= 1'b0;
    end
    else if (mode_q == ST_STANDBY)
    begin
      cnt_q <= {CNT_W{1'b0}};
      phase_q <= 1'b0;
      sample_strobe_q <= 1'b0; // see RQ13
      odr_strobe_q <= 1'b0;
    end
    else if (tick_w)
    begin
      cnt_q <= {CNT_W{1'b0}};
      phase_q <= low_power_q ? 1'b0 : ~phase_q;
      sample_strobe_q <= 1'b1;
      odr_strobe_q <= low_power_q | phase_q;
    end
    else
    begin
      cnt_q <= cnt_q + ONE_W;
      sample_strobe_q <= 1'b0;
      odr_strobe_q <= 1'b0;
    end
  end

  // ========================================================================
  // Inactivity counter, in output samples.
  // ========================================================================
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      inact_cnt_q <= 8'h00;
    end
    else if (mode_q != ST_MEASURE)
    begin
      inact_cnt_q <= 8'h00;
    end
    else if (odr_strobe_q)
    begin
      if (!sample_inactive)
      begin
        inact_cnt_q <= 8'h00;
      end
      else if (inact_cnt_q != 8'hFF)
      begin
        inact_cnt_q <= inact_cnt_q + 8'h01; // see RQ10
      end
    end
  end

endmodule

//--- apmc_top_props.sv
`timescale 1ns/1ps
`include "apmc_defines.vh"

// ===================================
// Port checks.
// ===================================
module apmc_top_props
(
  input wire clock,
  input wire rst,
  input wire cs_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_rd_valid_q,
  input wire i2c_mode_q,
  input wire [1:0] mode_q,
  input wire sense_enable_q,
  input wire sample_strobe_q,
  input wire odr_strobe_q,
  input wire low_power_q,
  input wire fifo_hold_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire wr_pc = reg_wr_en && reg_addr == `APMC_ADDR_POWER_CONTROL;
  property p_rd;
    reg_rd_en && !reg_wr_en |=> reg_rd_valid_q;
  endproperty
  a_rd: assert property (p_rd) else $error("no read valid");
  property p_wr;
    reg_wr_en |=> !reg_rd_valid_q;
  endproperty
  a_wr: assert property (p_wr) else $error("valid on write");
  property p_set;
    wr_pc && reg_wdata[3] |-> ##2 mode_q != 2'h0 && sense_enable_q;
  endproperty
  a_set: assert property (p_set) else $error("no measure");
  property p_clr;
    wr_pc && !reg_wdata[3] |-> ##2 mode_q == `APMC_MODE_STANDBY;
  endproperty
  a_clr: assert property (p_clr) else $error("no standby");
  property p_stby;
    mode_q == 2'h0 && $past(mode_q) == 2'h0 |-> !sample_strobe_q
      && !odr_strobe_q;
  endproperty
  a_stby: assert property (p_stby) else $error("strobe idle");
  property p_hold;
    fifo_hold_q == (mode_q == `APMC_MODE_STANDBY);
  endproperty
  a_hold: assert property (p_hold) else $error("hold wrong");
  property p_sleep;
    mode_q == `APMC_MODE_SLEEP |-> $past(mode_q) != 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep");
  property p_lp;
    reg_wr_en && reg_addr == `APMC_ADDR_RATE_LP |-> ##2
      low_power_q == $past(reg_wdata[4], 2);
  endproperty
  a_lp: assert property (p_lp) else $error("low power");
  property p_i2c;
    i2c_mode_q == $past(cs_n);
  endproperty
  a_i2c: assert property (p_i2c) else $error("mode pin");
  property p_odr;
    odr_strobe_q |-> sample_strobe_q;
  endproperty
  a_odr: assert property (p_odr) else $error("odr alone");
  c_sleep: cover property (mode_q == `APMC_MODE_SLEEP);
  c_lp: cover property (low_power_q && odr_strobe_q);
  c_rd: cover property (reg_rd_valid_q);
endmodule

bind apmc_top apmc_top_props chk_u (.clock(clock), .rst(rst),
  .cs_n(cs_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rd_valid_q(reg_rd_valid_q), .i2c_mode_q(i2c_mode_q),
  .mode_q(mode_q), .sense_enable_q(sense_enable_q),
  .sample_strobe_q(sample_strobe_q), .odr_strobe_q(odr_strobe_q),
  .low_power_q(low_power_q), .fifo_hold_q(fifo_hold_q));

//--- apmc_top_tb.sv
`timescale 1ns/1ps
`include "apmc_defines.vh"

// ===================================
// Testbench.
// ===================================
module apmc_top_tb;
  localparam int BASE = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic inact = 1'b0;
  logic act = 1'b0;
  wire cs_n, wr_en, rd_en, valid, i2c_q, sense_q, smp_q, odr_q, lp_q;
  wire hold_q;
  wire [7:0] addr, wdata, rdata, thr;
  wire [1:0] mode_q;
  int mismatches = 0;
  int n_checks = 0;
  int p;
  int s;
  int i;
  logic [7:0] d;

  always #50 clock = ~clock;

  apmc_host host_u (.clock(clock), .rdata(rdata), .valid(valid),
    .cs_n(cs_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  apmc_top #(.ODR_BASE_CYCLES(BASE)) dut_u (.clock(clock), .rst(rst),
    .cs_n(cs_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .sample_inactive(inact),
    .sample_active(act), .reg_rdata_q(rdata), .reg_rd_valid_q(valid),
    .i2c_mode_q(i2c_q), .mode_q(mode_q), .sense_enable_q(sense_q),
    .sample_strobe_q(smp_q), .odr_strobe_q(odr_q), .low_power_q(lp_q),
    .fifo_hold_q(hold_q), .inact_threshold_q(thr));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cycles from one output sample to the next, with internal samples.
  task per;
    for (p = 0; p < 9000 && odr_q !== 1'b1; p++)
      @(negedge clock);
    p = 0;
    s = 0;
    do
    begin
      @(negedge clock);
      p++;
      s += (smp_q === 1'b1);
    end
    while (odr_q !== 1'b1 && p < 9000);
  endtask
  task rw(input logic [7:0] a, r, w, e);
    host_u.rd(a, d);
    chk(d, r);
    host_u.wr(a, w);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task t_regs;
    chk(mode_q, `APMC_MODE_STANDBY);
    chk(sense_q, 1'b0);
    rw(`APMC_ADDR_INACT_THRESH, `APMC_RST_INACT_THRESH, 8'hA5, 8'hA5);
    rw(`APMC_ADDR_INACT_TIME, `APMC_RST_INACT_TIME, 8'h5A, 8'h5A);
    rw(`APMC_ADDR_RATE_LP, `APMC_RST_RATE_LP, 8'h1A, 8'h1A);
    rw(`APMC_ADDR_POWER_CONTROL, `APMC_RST_POWER_CONTROL, 8'h30, 8'h30);
    rw(8'h30, 8'h00, 8'h77, 8'h00);
    chk(mode_q, `APMC_MODE_STANDBY);
    chk(thr, 8'hA5);
  endtask
  task t_rate;
    for (i = 0; i < 6; i++)
    begin
      host_u.wr(`APMC_ADDR_RATE_LP, {3'h0, i > 2, 4'(15 - i)});
      host_u.wr(`APMC_ADDR_POWER_CONTROL, 8'h08);
      per();
      per();
      chk(p, BASE << i);
      chk(s, i > 2 ? 1 : 2);
      chk(lp_q, i > 2);
      chk(mode_q, `APMC_MODE_MEASURE);
      chk(sense_q, 1'b1);
      chk(hold_q, 1'b0);
      host_u.wr(`APMC_ADDR_POWER_CONTROL, 8'h00);
      repeat (2) @(negedge clock);
      chk(mode_q, `APMC_MODE_STANDBY);
      chk(hold_q, 1'b1);
    end
    s = 0;
    repeat (300)
    begin
      @(negedge clock);
      s += (smp_q === 1'b1);
    end
    chk(s, 0);
  endtask
  task t_sleep;
    host_u.wr(`APMC_ADDR_INACT_THRESH, 8'h10);
    host_u.wr(`APMC_ADDR_INACT_TIME, 8'h02);
    host_u.wr(`APMC_ADDR_RATE_LP, 8'h0F);
    inact = 1'b1;
    host_u.wr(`APMC_ADDR_POWER_CONTROL, 8'h38);
    for (i = 0; i < 200 && mode_q !== `APMC_MODE_SLEEP; i++)
      @(negedge clock);
    chk(mode_q, `APMC_MODE_SLEEP);
    per();
    per();
    chk(p, BASE << 9);
    inact = 1'b0;
    act = 1'b1;
    for (i = 0; i < 5000 && mode_q !== `APMC_MODE_MEASURE; i++)
      @(negedge clock);
    chk(mode_q, `APMC_MODE_MEASURE);
    act = 1'b0;
    host_u.wr(`APMC_ADDR_POWER_CONTROL, 8'h00);
    repeat (2) @(negedge clock);
    chk(mode_q, `APMC_MODE_STANDBY);
  endtask
  task t_cs;
    host_u.sel(1'b0);
    repeat (2) @(negedge clock);
    chk(i2c_q, 1'b0);
    host_u.sel(1'b1);
    repeat (2) @(negedge clock);
    chk(i2c_q, 1'b1);
  endtask

  initial
  begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_regs();
    t_rate();
    t_sleep();
    t_cs();
    results();
  end
  initial
  begin
    #6000000;
    mismatches++;
    results();
  end
endmodule
